// ### core/msp_serial_port.sv
/*
 * Serial control port of a dual-coil stepper driver. Receives 12-bit
 * control words on a select-framed serial link, shifts the status word
 * out, and drives the coil settings after a fixed delay, or at the start of the next frame if that comes first.
 * Assumes the serial pins come from another clock domain and that the
 * system clock is at least several times faster than the serial clock.
 */
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Serial output floats unless enabled and selected
// - Shifted-in bits reappear on serial output
// - Last twelve bits form word; extras ignored
// - Frames under twelve clocks are discarded
// - New word reaches outputs after select release
// - Zero current code switches coil fully off
module msp_serial_port (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Serial pins
   input wire logic i_sck,
   input wire logic i_sdi,
   input wire logic i_chip_select_n,
   input wire logic i_driver_enable_n,
   output logic o_sdo,
   output logic o_sdo_oe,
   // Status word to send, from on-chip logic
   input wire logic [msp_pkg::WORD_BITS-1:0] i_status,
   // Coil settings
   output msp_pkg::msp_ctrl_type o_ctrl,
   output logic o_coil_a_on,
   output logic o_coil_b_on,
   output logic o_bridge_enable,
   // Frame events
   output logic o_update,
   output logic o_frame_reject
);
   import msp_pkg::*;

   // Limitation: the serial clock must stay well below the system
   // clock; each of its phases needs at least four cycles here.
   // Whole module state in one record
   typedef struct packed {
      msp_pins_type meta;          // First sync stage, read by pin only
      msp_pins_type pin;           // Second sync stage
      logic sck_prev;              // Last synced clock level
      msp_state_type state;        // Sequencer state
      logic [WORD_BITS-1:0] shreg; // Shift register
      logic [CNT_BITS-1:0] count;  // Saturating bit counter
      logic [WORD_BITS-1:0] pend;  // Accepted word awaiting apply
      logic [TMR_BITS-1:0] timer;  // Update delay countdown
      msp_ctrl_type ctrl;          // Applied coil settings
      logic a_on;                  // Coil A current enabled
      logic b_on;                  // Coil B current enabled
      logic bridge_en;             // Port enabled
      logic sdo;                   // Serial out level
      logic sdo_oe;                // Serial out drive enable
      logic update;                // One-cycle apply pulse
      logic reject;                // One-cycle short-frame pulse
   } msp_state_rec_type;

   msp_state_rec_type s;      // Registered state
   msp_state_rec_type next_s; // Next state

   // Delay count as a sized constant
   // Typical latency is used, not a worst case
   localparam logic [TMR_BITS-1:0] UPD_CNT = TMR_BITS'(UPDATE_CYCLES);

   // Apply a word: store fields and recompute coil on flags
   function automatic msp_state_rec_type apply_word(
      input msp_state_rec_type r,
      input logic [WORD_BITS-1:0] w
   );
      msp_state_rec_type t;
      t = r;
      // Fields land as laid out on the wire
      t.ctrl = msp_ctrl_type'(w);
      // Zero code means bridge off, not a small current
      t.a_on = (w[POS_A_CUR_HI:POS_A_CUR_LO] != 4'h0);
      t.b_on = (w[POS_B_CUR_HI:POS_B_CUR_LO] != 4'h0);
      t.update = 1'b1;
      return t;
   endfunction

   // Begin a frame: load status and present its first bit
   // Used from idle and from the hold-off state
   function automatic msp_state_rec_type start_frame(
      input msp_state_rec_type r,
      input logic [WORD_BITS-1:0] st
   );
      msp_state_rec_type t;
      t = r;
      t.shreg = st;
      // Counter restarts every frame
      t.count = 4'h0;
      // First status bit stands before the first rise
      t.sdo = st[WORD_BITS-1];
      t.sdo_oe = 1'b1;
      t.state = ST_SHIFT;
      return t;
   endfunction

   // Edge and select decode on synchronised pins
   // Edges show in the same cycle the second stage changes
   logic sck_rise;
   logic sck_fall;
   logic selected;
   assign sck_rise = s.pin.sck & ~s.sck_prev;
   assign sck_fall = ~s.pin.sck & s.sck_prev;
   // Enable high mid-frame ends the frame like select
   // Port gated by enable; select alone is not enough
   assign selected = ~s.pin.chip_select_n & ~s.pin.driver_enable_n;

   // Next-state logic
   always_comb begin
      next_s = s;
      // Two-stage sync; only the second stage is read below
      // Trade-off: two flops add delay but stop metastability
      next_s.meta = '{sck: i_sck, sdi: i_sdi,
                      chip_select_n: i_chip_select_n,
                      driver_enable_n: i_driver_enable_n};
      next_s.pin = s.meta;
      next_s.sck_prev = s.pin.sck;
      // Bridge follows the synced enable
      next_s.bridge_en = ~s.pin.driver_enable_n;
      // Pulses last one cycle
      next_s.update = 1'b0;
      next_s.reject = 1'b0;
      // Sequencer: idle, shift, then hold-off
      case (s.state)
         // Wait for select
         ST_IDLE: begin
            next_s.sdo_oe = 1'b0;
            if (selected) begin
               // Status word captured at frame start
               next_s = start_frame(next_s, i_status);
            end
         end
         // Shift while selected
         ST_SHIFT: begin
            if (!selected) begin
               next_s.sdo_oe = 1'b0;
               // Frame over; decide by number of rises seen
               if (s.count >= MIN_BITS) begin
                  // Register holds the last twelve bits only
                  next_s.pend = s.shreg;
                  next_s.timer = UPD_CNT;
                  next_s.state = ST_WAIT;
               end else begin
                  // Too short, likely a spike: keep settings
                  next_s.reject = 1'b1;
                  next_s.state = ST_IDLE;
               end
            end else if (sck_rise) begin
               // Sample data; oldest bit falls out the top
               next_s.shreg = {s.shreg[WORD_BITS-2:0], s.pin.sdi};
               // Saturate so long chains cannot wrap the count
               if (s.count != MIN_BITS) begin
                  next_s.count = s.count + 4'h1;
               end
            end else if (sck_fall) begin
               // Present the bit shifted in earlier for chaining
               next_s.sdo = s.shreg[WORD_BITS-1];
            end
         end
         // Hold off the output change
         ST_WAIT: begin
            next_s.sdo_oe = 1'b0;
            if (selected) begin
               // A new frame forces the pending word out early
               next_s = apply_word(next_s, s.pend);
               next_s = start_frame(next_s, i_status);
            end else if (s.timer <= 9'h001) begin
               // Delay over: apply and return to idle
               next_s = apply_word(next_s, s.pend);
               next_s.state = ST_IDLE;
            end else begin
               // Still holding off
               next_s.timer = s.timer - 9'h001;
            end
         end
         default: begin
            // Unused code: recover to idle
            next_s.state = ST_IDLE;
            next_s.sdo_oe = 1'b0;
         end
      endcase
   end

   // State register, synchronous reset
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s <= '0;
         // Pins reset to idle levels so no false clock edge
         // follows release; the serial clock idles low
         s.meta <= PINS_IDLE;
         s.pin <= PINS_IDLE;
         s.ctrl <= msp_ctrl_type'(CTRL_RESET);
         s.state <= ST_IDLE;
      end else begin
         // Every register updates each edge; no enable
         s <= next_s;
      end
   end

   // Outputs straight from the state record
   // No logic between the flops and the pins
   assign o_sdo = s.sdo;
   assign o_sdo_oe = s.sdo_oe;
   assign o_ctrl = s.ctrl;
   assign o_coil_a_on = s.a_on;
   assign o_coil_b_on = s.b_on;
   assign o_bridge_enable = s.bridge_en;
   assign o_update = s.update;
   assign o_frame_reject = s.reject;

endmodule

`default_nettype wire

// ### common/msp_pkg.sv
/*
 * Shared constants and carrier types of the motor driver serial control
 * port: control word layout, frame length, update latency and state.
 * Assumes a single 100 MHz system clock; all pins arrive unsynchronised.
 */
`default_nettype none

package msp_pkg;

   // Word and frame geometry
   localparam int WORD_BITS = 12;        // Control word length
   localparam int CNT_BITS = 4;          // Bit counter width
   localparam logic [3:0] MIN_BITS = 4'hc; // Shortest accepted frame

   // Field positions inside the 12-bit control word
   localparam int POS_A_DECAY = 11;
   localparam int POS_A_CUR_HI = 10;
   localparam int POS_A_CUR_LO = 7;
   localparam int POS_A_POL = 6;
   localparam int POS_B_DECAY = 5;
   localparam int POS_B_CUR_HI = 4;
   localparam int POS_B_CUR_LO = 1;
   localparam int POS_B_POL = 0;

   // Timing: select release to output change
   localparam int CLK_PERIOD_NS = 10;    // System clock period
   localparam int UPDATE_DELAY_NS = 3000; // Typical output latency
   localparam int UPDATE_CYCLES = UPDATE_DELAY_NS / CLK_PERIOD_NS;
   localparam int TMR_BITS = 9;          // Holds UPDATE_CYCLES

   // Reset values
   localparam logic [11:0] CTRL_RESET = 12'h000; // Coils off

   // Decoded control word, laid out as it arrives
   typedef struct packed {
      logic a_decay;       // coil_a_mixed_decay
      logic [3:0] a_cur;   // Coil A current code
      logic a_pol;         // coil_a_polarity
      logic b_decay;       // coil_b_mixed_decay
      logic [3:0] b_cur;   // Coil B current code
      logic b_pol;         // coil_b_polarity
   } msp_ctrl_type;

   // Raw serial pins as one bundle
   typedef struct packed {
      logic sck;               // Serial clock
      logic sdi;               // Serial data in
      logic chip_select_n;     // Active low select
      logic driver_enable_n;   // Active low port enable
   } msp_pins_type;

   // Idle pin levels: clock low, select and enable high
   localparam msp_pins_type PINS_IDLE = '{sck: 1'b0, sdi: 1'b0,
      chip_select_n: 1'b1, driver_enable_n: 1'b1};

   // Port sequencing states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SHIFT,
      ST_WAIT
   } msp_state_type;

endpackage

`default_nettype wire

// ### test/msp_serial_port_props.sv
/* Checker of msp_serial_port pins and coil outputs.
   Assumes one clock domain and a synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module msp_props
   import msp_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Serial pins
   input wire logic i_sck,
   input wire logic i_chip_select_n,
   input wire logic i_driver_enable_n,
   input wire logic o_sdo,
   input wire logic o_sdo_oe,
   // Coil results
   input wire msp_ctrl_type o_ctrl,
   input wire logic o_coil_a_on,
   input wire logic o_coil_b_on,
   input wire logic o_update,
   input wire logic o_frame_reject
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Select falls while enabled
   sequence s_start; $fell(i_chip_select_n) && !i_driver_enable_n; endsequence
   // No load, word held
   sequence s_keep; !o_update ##1 $stable(o_ctrl)[*8]; endsequence
   a_float_sel: assert property (i_chip_select_n[*6] |-> !o_sdo_oe)
      else $error("sdo driven while deselected");
   a_float_en: assert property (i_driver_enable_n[*6] |-> !o_sdo_oe)
      else $error("sdo driven while disabled");
   a_oe_on: assert property (s_start |-> ##[2:5] o_sdo_oe)
      else $error("sdo not driven after select");
   // Sync delay is three clocks, sck low phase is four
   a_sdo_fall: assert property (o_sdo_oe && $past(o_sdo_oe)
      && $changed(o_sdo) |-> !$past(i_sck)) else $error("sdo moved off fall");
   a_coil_off: assert property (o_coil_a_on == (o_ctrl.a_cur != 4'h0)
      && o_coil_b_on == (o_ctrl.b_cur != 4'h0)) else $error("coil flag wrong");
   a_upd_cause: assert property ($changed(o_ctrl) |-> o_update)
      else $error("ctrl changed without update");
   a_upd_late: assert property (o_update |-> $past(i_chip_select_n, 300))
      else $error("update too early");
   a_rej_keep: assert property (o_frame_reject |-> s_keep)
      else $error("short frame changed ctrl");
endmodule
bind msp_serial_port msp_props u_props (.i_clk(i_clk), .i_rst(i_rst),
   .i_sck(i_sck), .i_chip_select_n(i_chip_select_n),
   .i_driver_enable_n(i_driver_enable_n), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
   .o_ctrl(o_ctrl), .o_coil_a_on(o_coil_a_on), .o_coil_b_on(o_coil_b_on),
   .o_update(o_update), .o_frame_reject(o_frame_reject));
`default_nettype wire

// ### test/msp_host_model.sv
/* Host side of the serial link, a bus master.
   Assumes a 100 MHz clock; sck is 80 ns, still outside frames. */
`timescale 1ns/10ps
`default_nettype none
module msp_host_model (
   // Clock
   input wire logic i_clk,
   // Pins toward device
   output logic o_sck,
   output logic o_sdi,
   output logic o_cs_n,
   output logic o_en_n,
   // Data back
   input wire logic i_sdo,
   input wire logic i_sdo_oe,
   output logic [15:0] o_rx
);
   logic line; // Resolved sdo wire
   // No pull resistor: a floating wire shows the inverse bit
   assign line = i_sdo_oe ? i_sdo : ~o_rx[0];
   initial begin
      o_sck = 1'b0;
      o_sdi = 1'b0;
      o_cs_n = 1'b1;
      o_en_n = 1'b1;
      o_rx = 16'h0000;
   end
   task set_en(input logic v);
      @(posedge i_clk);
      o_en_n <= v;
   endtask
   // MSB first, device samples on rise, host on rise too
   task xfer(input logic [15:0] w, input int n);
      @(posedge i_clk);
      o_cs_n <= 1'b0;
      repeat (8) @(posedge i_clk);
      for (int i = n - 1; i >= 0; i--) begin
         o_sdi <= w[i];
         repeat (4) @(posedge i_clk);
         o_sck <= 1'b1;
         o_rx <= {o_rx[14:0], line};
         repeat (4) @(posedge i_clk);
         o_sck <= 1'b0;
      end
      repeat (8) @(posedge i_clk);
      o_cs_n <= 1'b1;
      o_sdi <= ~o_sdi;
   endtask
endmodule
`default_nettype wire

// ### test/test_motor_driver_serial_ctrl_port.sv
/* Testbench of msp_serial_port, driven through the host model.
   Assumes the checker is bound in; runs a few thousand cycles. */
`timescale 1ns/10ps
`default_nettype none
module test_motor_driver_serial_ctrl_port;
   import msp_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic sck, sdi, cs_n, en_n, sdo, oe, coil_a, coil_b, upd, rej, bridge;
   logic [15:0] rx;
   msp_ctrl_type ctrl;
   int n_errors = 0, n_compared = 0, cyc = 0, wt;
   msp_serial_port DUT (.i_clk(i_clk), .i_rst(i_rst), .i_sck(sck),
      .i_sdi(sdi), .i_chip_select_n(cs_n), .i_driver_enable_n(en_n),
      .o_sdo(sdo), .o_sdo_oe(oe), .i_status(12'h3c5), .o_ctrl(ctrl),
      .o_coil_a_on(coil_a), .o_coil_b_on(coil_b), .o_bridge_enable(bridge),
      .o_update(upd), .o_frame_reject(rej));
   msp_host_model host (.i_clk(i_clk), .o_sck(sck), .o_sdi(sdi),
      .o_cs_n(cs_n), .o_en_n(en_n), .i_sdo(sdo), .i_sdo_oe(oe), .o_rx(rx));
   initial forever #5 i_clk = ~i_clk;
   // Hang guard
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task chk(string nm, logic [15:0] seen, logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // Bounded wait for update (0) or reject (1)
   task wait_ev(input bit r);
      wt = 0;
      while ((r ? rej : upd) !== 1'b1 && wt < 500) begin
         @(posedge i_clk);
         #1;
         wt++;
      end
   endtask
   task report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (10) @(posedge i_clk);
      #1;
      chk("oe_idle", {15'h0, oe}, 16'h0);
      chk("bridge_off", {15'h0, bridge}, 16'h0);
      host.xfer(16'h0a41, 12);
      wait_ev(0);
      chk("ctrl_off", {4'h0, ctrl}, 16'h0);
      $display("test disabled done");
      host.set_en(1'b0);
      host.xfer(16'h0a41, 12);
      wait_ev(0);
      chk("latency", {15'h0, wt >= 300 && wt <= 310}, 16'h1);
      chk("ctrl12", {4'h0, ctrl}, 16'h0a41);
      chk("coils", {14'h0, coil_a, coil_b}, 16'h2);
      chk("bridge_on", {15'h0, bridge}, 16'h1);
      chk("sdo12", {4'h0, rx[11:0]}, 16'h03c5);
      $display("test frame12 done");
      host.xfer(16'hf5be, 16);
      wait_ev(0);
      chk("ctrl16", {4'h0, ctrl}, 16'h05be);
      chk("coils16", {14'h0, coil_a, coil_b}, 16'h3);
      chk("sdo16", rx, 16'h3c5f);
      $display("test frame16 done");
      host.xfer(16'h0000, 11);
      wait_ev(1);
      chk("reject", {15'h0, rej}, 16'h1);
      repeat (400) @(posedge i_clk);
      chk("ctrl_kept", {4'h0, ctrl}, 16'h05be);
      $display("test short done");
      host.xfer(16'h0000, 12);
      wait_ev(0);
      chk("zero", {ctrl, coil_a, coil_b, 2'h0}, 16'h0);
      $display("test zero done");
      report_and_stop();
   end
endmodule
`default_nettype wire
